// File: rtl/ccs_clock_source_config.sv
/*
  Clock source configuration of an audio codec: register file, PLL
  control outputs, input clock selection, source to frame sync ratio
  measurement and microphone / reference clock rate decode.
  Assumes the register port is synchronous to sys_clk and that all clock
  and frame sync pins are asynchronous and much slower than sys_clk.
*/
// What this block does
// - PLL off when bit set; else always on custom, on-demand in auto.
// - Fractional permit bit allows fractional PLL; resets to one.
// - Choice 0 selects primary bit clock, 2 secondary bit clock.
// - Choice 1 and 3 use reference clock with primary/secondary sync.
// - Choice 4 uses fixed reference clock only with a controller port.
// - Choice 5 selects internal oscillator; 6 and 7 are reserved.
// - Ratio edge bit picks rising or falling source edge for counting.
// - Two-bit mic clock field selects one of four microphone rates.
// - Ratio is 14 bits: six high from 0x35, eight low from 0x36.
// - Ratio zero means the ratio is detected automatically.
// - Ratio 1 to 16383 is used as programmed.
// - Rate family bit picks 48 kHz or 44.1 kHz mic rates.
// - Three-bit field declares fixed reference frequency, 12 to 24.576 MHz.
`timescale 1ns/1ps
`default_nettype none

module ccs_clock_source_config
  import ccs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output var  logic [7:0]  regRdData,
  input  wire logic        priBitClk,
  input  wire logic        priFrameSync,
  input  wire logic        secBitClk,
  input  wire logic        secFrameSync,
  input  wire logic        refClk,
  input  wire logic        customClockMode,
  input  wire logic        dspLoadHigh,
  output var  logic        pllEnable,
  output var  logic        fractionalPermit,
  output var  logic [2:0]  inputClockChoice,
  output var  logic        sourceValid,
  output var  logic [22:0] micClockHz,
  output var  logic [14:0] refFreqKhz,
  output var  logic [13:0] ratioInUse,
  output var  logic        ratioAuto,
  output var  logic [13:0] measuredRatio
);
  import ccs_pkg::*;

  // ===========================================================
  // Pin synchronisers
  logic [4:0] pinSync;

  ccs_sync2 #(
    .WIDTH (5)
  ) u_sync (
    .clk     (sys_clk),
    .rst_n   (rst_n),
    .asyncIn ({refClk, secFrameSync, secBitClk, priFrameSync, priBitClk}),
    .syncOut (pinSync)
  );

  logic priBitS;
  logic priFsS;
  logic secBitS;
  logic secFsS;
  logic refS;
  assign priBitS = pinSync[0];
  assign priFsS  = pinSync[1];
  assign secBitS = pinSync[2];
  assign secFsS  = pinSync[3];
  assign refS    = pinSync[4];

  // ===========================================================
  // State
  logic [7:0]  srcCfg_reg,  srcCfg_next;
  logic [7:0]  highCfg_reg, highCfg_next;
  logic [7:0]  lowCfg_reg,  lowCfg_next;
  logic [7:0]  ctrlCfg_reg, ctrlCfg_next;
  logic [13:0] ratio_reg,   ratio_next;
  logic [7:0]  rdData_reg,  rdData_next;
  logic [3:0]  oscCnt_reg,  oscCnt_next;
  logic        osc_reg,     osc_next;
  logic        srcPrev_reg, srcPrev_next;
  logic        fsPrev_reg,  fsPrev_next;
  logic [13:0] edgeCnt_reg, edgeCnt_next;
  logic [13:0] meas_reg,    meas_next;
  logic        pll_reg,     pll_next;
  logic        frac_reg,    frac_next;
  logic [2:0]  choice_reg,  choice_next;
  logic        valid_reg,   valid_next;
  logic [22:0] micHz_reg,   micHz_next;
  logic [14:0] refKhz_reg,  refKhz_next;
  logic [13:0] inUse_reg,   inUse_next;
  logic        auto_reg,    auto_next;

  // ===========================================================
  // Next-state logic
  logic [2:0] wrChoice;
  logic [2:0] choice;
  logic       srcLevel;
  logic       fsLevel;
  logic       srcEdge;
  logic       fsRise;
  logic       anyController;

  always_comb begin
    srcCfg_next  = srcCfg_reg;
    highCfg_next = highCfg_reg;
    lowCfg_next  = lowCfg_reg;
    ctrlCfg_next = ctrlCfg_reg;
    ratio_next   = ratio_reg;
    rdData_next  = rdData_reg;
    wrChoice     = regWrData[CHOICE_LSB +: 3];

    if (regWrEn) begin
      case (regAddr)
        CLOCK_SOURCE_CONFIG_ADDR: begin
          srcCfg_next = regWrData & CLOCK_SOURCE_CONFIG_MASK;
          if (wrChoice > SRC_OSCILLATOR) begin
            srcCfg_next[CHOICE_LSB +: 3] = srcCfg_reg[CHOICE_LSB +: 3];
          end
        end
        PDM_AND_RATIO_HIGH_ADDR: begin
          highCfg_next = regWrData;
        end
        REF_RATIO_LOW_ADDR: begin
          lowCfg_next = regWrData;
          ratio_next = {highCfg_reg[RATIO_HIGH_W-1:0], regWrData};
        end
        CTRL_CLOCK_CONFIG_ADDR: begin
          ctrlCfg_next = regWrData & CTRL_CLOCK_CONFIG_MASK;
        end
        default: begin
        end
      endcase
    end

    // Unmapped addresses read as zero.
    if (regRdEn) begin
      case (regAddr)
        CLOCK_SOURCE_CONFIG_ADDR: rdData_next = srcCfg_reg;
        PDM_AND_RATIO_HIGH_ADDR:  rdData_next = highCfg_reg;
        REF_RATIO_LOW_ADDR:       rdData_next = lowCfg_reg;
        CTRL_CLOCK_CONFIG_ADDR:   rdData_next = ctrlCfg_reg;
        default:                  rdData_next = 8'h00;
      endcase
    end

    // The oscillator is modelled by dividing sys_clk; its exact rate
    // only matters for the ratio count, not for any audio path here.
    oscCnt_next = oscCnt_reg + 4'h1;
    osc_next    = osc_reg;
    if (oscCnt_reg == OSC_HALF_CYCLES - 4'h1) begin
      oscCnt_next = 4'h0;
      osc_next    = ~osc_reg;
    end

    choice        = srcCfg_reg[CHOICE_LSB +: 3];
    anyController = ctrlCfg_reg[PRI_CONTROLLER_BIT]
                  | ctrlCfg_reg[SEC_CONTROLLER_BIT];
    valid_next    = 1'b1;
    srcLevel      = 1'b0;
    fsLevel       = priFsS;
    case (choice)
      SRC_PRI_BIT_CLK: srcLevel = priBitS;
      SRC_REF_PRI_FS:  srcLevel = refS;
      SRC_SEC_BIT_CLK: begin
        srcLevel = secBitS;
        fsLevel  = secFsS;
      end
      SRC_REF_SEC_FS: begin
        srcLevel = refS;
        fsLevel  = secFsS;
      end
      SRC_REF_FIXED: begin
        srcLevel   = anyController & refS;
        valid_next = anyController;
      end
      SRC_OSCILLATOR:  srcLevel = osc_reg;
      default:         valid_next = 1'b0;
    endcase

    // edge polarity of the counted source
    srcEdge = srcCfg_reg[RATIO_EDGE_BIT] ? (srcPrev_reg & ~srcLevel)
                                         : (~srcPrev_reg & srcLevel);
    fsRise       = ~fsPrev_reg & fsLevel;
    srcPrev_next = srcLevel;
    fsPrev_next  = fsLevel;

    // Saturating count of source edges per frame; a slow frame sync
    // therefore reads as the largest ratio rather than wrapping.
    edgeCnt_next = edgeCnt_reg;
    meas_next    = meas_reg;
    if (fsRise) begin
      meas_next    = edgeCnt_reg;
      edgeCnt_next = {13'h0000, srcEdge};
    end else if (srcEdge && edgeCnt_reg != RATIO_MAX) begin
      edgeCnt_next = edgeCnt_reg + 14'h0001;
    end

    pll_next = ~srcCfg_reg[PHASE_LOCK_OFF_BIT]
             & (customClockMode | dspLoadHigh);
    frac_next   = srcCfg_reg[FRACTIONAL_PERMIT_BIT];
    choice_next = choice;

    micHz_next = ctrlCfg_reg[RATE_FAMILY_BIT]
               ? MIC_HZ_44K[highCfg_reg[MIC_RATE_LSB +: 2]]
               : MIC_HZ_48K[highCfg_reg[MIC_RATE_LSB +: 2]];
    refKhz_next = REF_KHZ[ctrlCfg_reg[REF_FREQ_LSB +: 3]];

    auto_next  = (ratio_reg == 14'h0000);
    inUse_next = auto_next ? meas_reg : ratio_reg;
  end

  // ===========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      srcCfg_reg  <= CLOCK_SOURCE_CONFIG_RST;
      highCfg_reg <= PDM_AND_RATIO_HIGH_RST;
      lowCfg_reg  <= REF_RATIO_LOW_RST;
      ctrlCfg_reg <= CTRL_CLOCK_CONFIG_RST;
      ratio_reg   <= 14'h0000;
      rdData_reg  <= 8'h00;
      oscCnt_reg  <= 4'h0;
      osc_reg     <= 1'b0;
      srcPrev_reg <= 1'b0;
      fsPrev_reg  <= 1'b0;
      edgeCnt_reg <= 14'h0000;
      meas_reg    <= 14'h0000;
      pll_reg     <= 1'b0;
      frac_reg    <= 1'b1;
      choice_reg  <= SRC_PRI_BIT_CLK;
      valid_reg   <= 1'b1;
      micHz_reg   <= 23'h000000;
      refKhz_reg  <= 15'h0000;
      inUse_reg   <= 14'h0000;
      auto_reg    <= 1'b1;
    end else begin
      srcCfg_reg  <= srcCfg_next;
      highCfg_reg <= highCfg_next;
      lowCfg_reg  <= lowCfg_next;
      ctrlCfg_reg <= ctrlCfg_next;
      ratio_reg   <= ratio_next;
      rdData_reg  <= rdData_next;
      oscCnt_reg  <= oscCnt_next;
      osc_reg     <= osc_next;
      srcPrev_reg <= srcPrev_next;
      fsPrev_reg  <= fsPrev_next;
      edgeCnt_reg <= edgeCnt_next;
      meas_reg    <= meas_next;
      pll_reg     <= pll_next;
      frac_reg    <= frac_next;
      choice_reg  <= choice_next;
      valid_reg   <= valid_next;
      micHz_reg   <= micHz_next;
      refKhz_reg  <= refKhz_next;
      inUse_reg   <= inUse_next;
      auto_reg    <= auto_next;
    end
  end

  // ===========================================================
  // Outputs
  assign regRdData        = rdData_reg;
  assign pllEnable        = pll_reg;
  assign fractionalPermit = frac_reg;
  assign inputClockChoice = choice_reg;
  assign sourceValid      = valid_reg;
  assign micClockHz       = micHz_reg;
  assign refFreqKhz       = refKhz_reg;
  assign ratioInUse       = inUse_reg;
  assign ratioAuto        = auto_reg;
  assign measuredRatio    = meas_reg;

endmodule

`default_nettype wire

// File: rtl/ccs_pkg.sv
/*
  Constants of the codec clock source configuration block: register
  offsets, field positions, reset values and lookup tables.
  Assumes the register port presents 8-bit byte addresses.
*/
package ccs_pkg;

  // ===========================================================
  // Register offsets
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_ADDR = 8'h34;
  localparam logic [7:0] PDM_AND_RATIO_HIGH_ADDR  = 8'h35;
  localparam logic [7:0] REF_RATIO_LOW_ADDR       = 8'h36;
  localparam logic [7:0] CTRL_CLOCK_CONFIG_ADDR   = 8'h37;

  // ===========================================================
  // Reset values
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_RST = 8'h40;
  localparam logic [7:0] PDM_AND_RATIO_HIGH_RST  = 8'h00;
  localparam logic [7:0] REF_RATIO_LOW_RST       = 8'h00;
  localparam logic [7:0] CTRL_CLOCK_CONFIG_RST   = 8'h20;

  // ===========================================================
  // Field positions of clock_source_config
  localparam int PHASE_LOCK_OFF_BIT    = 7;
  localparam int FRACTIONAL_PERMIT_BIT = 6;
  localparam int CHOICE_LSB            = 1;
  localparam int RATIO_EDGE_BIT        = 0;
  // Writable bits; bits 5 and 4 are reserved and read as zero.
  localparam logic [7:0] CLOCK_SOURCE_CONFIG_MASK = 8'hCF;

  // Field positions of pdm_and_ratio_high
  localparam int MIC_RATE_LSB = 6;
  localparam int RATIO_HIGH_W = 6;

  // Field positions of ctrl_clock_config
  localparam int REF_FREQ_LSB      = 5;
  localparam int PRI_CONTROLLER_BIT = 4;
  localparam int SEC_CONTROLLER_BIT = 3;
  localparam int RATE_FAMILY_BIT    = 0;
  localparam logic [7:0] CTRL_CLOCK_CONFIG_MASK = 8'hF9;

  // ===========================================================
  // Input clock choice codes
  localparam logic [2:0] SRC_PRI_BIT_CLK = 3'h0;
  localparam logic [2:0] SRC_REF_PRI_FS  = 3'h1;
  localparam logic [2:0] SRC_SEC_BIT_CLK = 3'h2;
  localparam logic [2:0] SRC_REF_SEC_FS  = 3'h3;
  localparam logic [2:0] SRC_REF_FIXED   = 3'h4;
  localparam logic [2:0] SRC_OSCILLATOR  = 3'h5;

  // ===========================================================
  // Ratio width and counters
  localparam int RATIO_W = 14;
  localparam logic [13:0] RATIO_MAX = 14'h3FFF;
  // Half period of the internal oscillator model, in sys_clk cycles.
  localparam logic [3:0] OSC_HALF_CYCLES = 4'h8;

  // ===========================================================
  // Microphone clock rates in Hz, one table per family, indexed by rate code.
  localparam logic [22:0] MIC_HZ_48K [0:3] = '{
    23'h2EE000, 23'h177000, 23'h0BB800, 23'h5DC000};
  localparam logic [22:0] MIC_HZ_44K [0:3] = '{
    23'h2B1100, 23'h158880, 23'h0AC440, 23'h562200};

  // Reference clock frequency in kHz per ref_frequency_choice code.
  localparam logic [14:0] REF_KHZ [0:7] = '{
    15'h2EE0, 15'h3000, 15'h32C8, 15'h3E80,
    15'h4B00, 15'h4CE0, 15'h5DC0, 15'h6000};

endpackage

// File: rtl/ccs_sync2.sv
/*
  Two-flop synchroniser, one chain per bit.
  Assumes the inputs are asynchronous to clk and that reset is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // ===========================================================
  // Per-bit chains
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stage1_reg[i] <= 1'b0;
          syncOut[i]    <= 1'b0;
        end else begin
          stage1_reg[i] <= asyncIn[i];
          syncOut[i]    <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: bench/ccs_properties.sv
/*
  Checker for the clock source configuration block.
  Assumes a bind onto ccs_clock_source_config and sight of its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_properties
  import ccs_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire logic        pllEnable,
  input wire logic        fractionalPermit,
  input wire logic [2:0]  inputClockChoice,
  input wire logic [22:0] micClockHz,
  input wire logic [13:0] ratioInUse,
  input wire logic        ratioAuto
);
  import ccs_pkg::*;
  logic        w34;
  logic        w35;
  logic        w36;
  logic [5:0]  hiShadow_reg;
  logic [5:0]  hiShadow_next;
  logic [13:0] expRatio_reg;
  logic [13:0] expRatio_next;

  // ============================================================
  // Shadow of the stored high ratio byte
  assign w34 = regWrEn && regAddr == CLOCK_SOURCE_CONFIG_ADDR;
  assign w35 = regWrEn && regAddr == PDM_AND_RATIO_HIGH_ADDR;
  assign w36 = regWrEn && regAddr == REF_RATIO_LOW_ADDR;
  always_comb begin
    hiShadow_next = w35 ? regWrData[5:0] : hiShadow_reg;
    expRatio_next = w36 ? {hiShadow_reg, regWrData} : expRatio_reg;
  end
  always_ff @(posedge sys_clk) begin
    hiShadow_reg <= rst_n ? hiShadow_next : 6'h00;
    expRatio_reg <= rst_n ? expRatio_next : 14'h0000;
  end

  // ============================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A write at one edge reaches the ratio output two edges later.
  sequence quietRatio;
    !w36 [*3];
  endsequence

  a_pll_off: assert property (w34 && regWrData[7] |-> ##2 !pllEnable)
    else $error("pll stays enabled while disabled");
  a_frac_follow: assert property (w34 |-> ##2
    fractionalPermit == $past(regWrData[6], 2))
    else $error("fractional permit does not follow write");
  a_reserved_zero: assert property (regRdEn &&
    regAddr == CLOCK_SOURCE_CONFIG_ADDR |=> regRdData[5:4] == 2'h0)
    else $error("reserved bits read nonzero");
  a_choice_follow: assert property (w34 && regWrData[3:1] < 3'h6
    |-> ##2 inputClockChoice == $past(regWrData[3:1], 2))
    else $error("input clock choice does not follow write");
  a_choice_reject: assert property (w34 && regWrData[3:1] > 3'h5
    |-> ##2 $stable(inputClockChoice))
    else $error("reserved choice code accepted");
  a_mic_rate: assert property (w35 |-> ##2
    micClockHz == MIC_HZ_48K[$past(regWrData[7:6], 2)] ||
    micClockHz == MIC_HZ_44K[$past(regWrData[7:6], 2)])
    else $error("mic clock rate not decoded");
  a_ratio_used: assert property (w36 && {hiShadow_reg, regWrData} !=
    14'h0000 |-> ##2 !ratioAuto && ratioInUse == $past(expRatio_reg))
    else $error("programmed ratio not used");
  a_ratio_auto: assert property (w36 && {hiShadow_reg, regWrData} ==
    14'h0000 |-> ##2 ratioAuto)
    else $error("zero ratio not auto");
  a_ratio_atomic: assert property (quietRatio ##0
    (!ratioAuto && !$past(ratioAuto)) |-> $stable(ratioInUse))
    else $error("ratio changed without low byte write");
  a_unmapped_read: assert property (regRdEn && (regAddr < 8'h34 ||
    regAddr > 8'h37) |=> regRdData == 8'h00)
    else $error("unmapped read nonzero");
endmodule

bind ccs_clock_source_config ccs_properties u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .pllEnable(pllEnable),
  .fractionalPermit(fractionalPermit), .inputClockChoice(inputClockChoice),
  .micClockHz(micClockHz), .ratioInUse(ratioInUse), .ratioAuto(ratioAuto));
`default_nettype wire

// File: bench/ccs_host_model.sv
/*
  Audio serial host: free running bit clocks, one-bit frame syncs and a
  reference clock locked to the primary frame. Assumes nothing of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_host_model #(
  parameter int PRI_BITS = 32,
  parameter int SEC_BITS = 16
) (
  output var logic priBitClk,
  output var logic priFrameSync,
  output var logic secBitClk,
  output var logic secFrameSync,
  output var logic refClk
);
  // Frame syncs move on falling bit clock edges, as a host would drive them.
  initial begin
    priBitClk = 1'b0;
    priFrameSync = 1'b0;
    #7;
    forever for (int i = 0; i < PRI_BITS; i++) begin
      priFrameSync = (i == 0);
      #32 priBitClk = 1'b1;
      #32 priBitClk = 1'b0;
    end
  end
  initial begin
    secBitClk = 1'b0;
    secFrameSync = 1'b0;
    #19;
    forever for (int i = 0; i < SEC_BITS; i++) begin
      secFrameSync = (i == 0);
      #32 secBitClk = 1'b1;
      #32 secBitClk = 1'b0;
    end
  end
  // Two bit clocks per reference period keeps it locked to both frames.
  initial begin
    refClk = 1'b0;
    #7;
    forever #64 refClk = ~refClk;
  end
endmodule
`default_nettype wire

// File: bench/ccs_clock_source_config_tb.sv
/*
  Self-checking bench of the clock source configuration block.
  Assumes ccs_host_model drives the clock and frame sync pins.
*/
`timescale 1ns/1ps
`default_nettype none

module ccs_clock_source_config_tb;
  import ccs_pkg::*;
  logic sys_clk, rst_n, regWrEn, regRdEn, customClockMode, dspLoadHigh;
  logic [7:0] regAddr, regWrData, regRdData, d, expCfg;
  logic pBc, pFs, sBc, sFs, refClk, pllEnable, fractionalPermit, sourceValid;
  logic [2:0] inputClockChoice;
  logic [22:0] micClockHz;
  logic [14:0] refFreqKhz;
  logic [13:0] ratioInUse, measuredRatio, r, prevRatio;
  logic ratioAuto;
  int n_errors = 0;
  int tests_run = 0;

  ccs_clock_source_config u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .priBitClk(pBc),
    .priFrameSync(pFs), .secBitClk(sBc), .secFrameSync(sFs), .refClk(refClk),
    .customClockMode(customClockMode), .dspLoadHigh(dspLoadHigh),
    .pllEnable(pllEnable), .fractionalPermit(fractionalPermit),
    .inputClockChoice(inputClockChoice), .sourceValid(sourceValid),
    .micClockHz(micClockHz), .refFreqKhz(refFreqKhz), .ratioInUse(ratioInUse),
    .ratioAuto(ratioAuto), .measuredRatio(measuredRatio));
  ccs_host_model u_host (.priBitClk(pBc), .priFrameSync(pFs),
    .secBitClk(sBc), .secFrameSync(sFs), .refClk(refClk));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ============================================================
  // Shared tasks
  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
    cyc(1);
    regWrEn = 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    {regAddr, regRdEn} = {a, 1'b1};
    cyc(1);
    regRdEn = 1'b0;
    check(regRdData, exp);
  endtask
  // Counts wander by one edge as the pins are resampled by sys_clk.
  task automatic wait_count(input logic [13:0] exp);
    int i;
    // Let the partial frame after a source switch pass first; it could
    // otherwise match by chance and hide a wrong steady count.
    cyc(830);
    for (i = 0; i < 3000; i++) begin
      cyc(1);
      if (measuredRatio + 14'h1 >= exp && measuredRatio <= exp + 14'h1) break;
    end
    check(i < 3000, 1);
    if (i >= 3000) close_out();
  endtask
  function automatic logic [7:0] next_cfg(input logic [7:0] v);
    return {v[7:6], 2'h0, v[3:1] > 3'h5 ? expCfg[3:1] : v[3:1], v[0]};
  endfunction

  initial begin
    #400000;
    n_errors++;
    close_out();
  end

  initial begin
    {rst_n, regWrEn, regRdEn, customClockMode, dspLoadHigh} = 5'h00;
    {regAddr, regWrData} = 16'h0000;
    prevRatio = 14'h0000;
    void'($urandom(46));
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    rd(8'h34, 8'h40); rd(8'h35, 8'h00); rd(8'h36, 8'h00); rd(8'h37, 8'h20);
    rd(8'h33, 8'h00); rd(8'h38, 8'h00);
    check(fractionalPermit, 1);
    expCfg = 8'h40;
    for (int i = 0; i < 24; i++) begin
      // Software keeps the reserved bits at zero.
      d = 8'($urandom) & CLOCK_SOURCE_CONFIG_MASK;
      {customClockMode, dspLoadHigh} = 2'($urandom);
      wr(8'h34, d);
      expCfg = next_cfg(d);
      rd(8'h34, expCfg);
      check(fractionalPermit, expCfg[6]);
      check(inputClockChoice, expCfg[3:1]);
      check(pllEnable, !d[7] && (customClockMode || dspLoadHigh));
    end
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom) & CTRL_CLOCK_CONFIG_MASK;
      r = i == 0 ? 14'h0000 : i == 1 ? 14'h3FFF
        : i == 2 ? 14'h0001 : 14'($urandom);
      wr(8'h37, d);
      rd(8'h37, d & CTRL_CLOCK_CONFIG_MASK);
      check(refFreqKhz, REF_KHZ[d[7:5]]);
      wr(8'h35, {i[1:0], r[13:8]});
      check(micClockHz, d[0] ? MIC_HZ_44K[i[1:0]]
                             : MIC_HZ_48K[i[1:0]]);
      if (prevRatio != 14'h0000) check(ratioInUse, prevRatio);
      wr(8'h36, r[7:0]);
      check(ratioAuto, r == 14'h0000);
      if (r != 14'h0000) check(ratioInUse, r);
      prevRatio = r;
    end
    wr(8'h37, 8'h20);
    wr(8'h34, 8'h08);
    check(sourceValid, 0);
    wr(8'h34, 8'h00); wait_count(14'd32);
    wr(8'h34, 8'h02); wait_count(14'd16);
    wr(8'h34, 8'h06); wait_count(14'd8);
    wr(8'h34, 8'h04); wait_count(14'd16);
    wr(8'h34, 8'h0A); wait_count(14'd26);
    wr(8'h34, 8'h0C);
    check(inputClockChoice, 3'h5);
    wr(8'h34, 8'h01); wait_count(14'd32);
    wr(8'h37, 8'h30);
    wr(8'h34, 8'h08); wait_count(14'd16);
    check(sourceValid, 1);
    wr(8'h35, 8'h00);
    wr(8'h36, 8'h00);
    check(ratioAuto, 1);
    check(ratioInUse, 14'd16);
    close_out();
  end
endmodule
`default_nettype wire
